// ### timer8_counter_compare_unit.v
// Counter and two-channel output compare unit of an 8-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "timer8_map.vh"

module timer8_counter_compare_unit (
    input wire clk,
    input wire rst_b,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [6:0] tick_sources,
    input wire ack_match_a,
    input wire ack_match_b,
    input wire ack_overflow,
    input wire port_value_a,
    input wire port_value_b,
    input wire output_pin_direction_a,
    input wire output_pin_direction_b,
    output reg [7:0] rdata_ff,
    output reg irq_match_a_ff,
    output reg irq_match_b_ff,
    output reg irq_overflow_ff,
    output reg pin_a_out_ff,
    output reg pin_a_oe_ff,
    output reg pin_b_out_ff,
    output reg pin_b_oe_ff,
    output reg at_bottom_ff,
    output reg at_max_ff
);

    // ****************************************
    // Helpers
    // ****************************************
    // Non-PWM match action on an output state
    function plain_action;
        input [1:0] com;
        input cur;
        begin
            case (com)
                `COM_TOGGLE: plain_action = ~cur;
                `COM_CLEAR: plain_action = 1'b0;
                `COM_SET: plain_action = 1'b1;
                default: plain_action = cur;
            endcase
        end
    endfunction

    // PWM action; match_level_hi selects the level that a match drives to
    function pwm_action;
        input [1:0] com;
        input cur;
        input match_level_hi;
        begin
            case (com)
                `COM_CLEAR: pwm_action = ~match_level_hi;
                `COM_SET: pwm_action = match_level_hi;
                default: pwm_action = cur;
            endcase
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg [7:0] timer_control_a_ff;
    reg [7:0] timer_control_b_ff;
    reg [7:0] count_value_ff;
    reg [7:0] compare_value_a_ff;
    reg [7:0] compare_value_b_ff;
    reg [7:0] buffer_a_ff;
    reg [7:0] buffer_b_ff;
    reg match_flag_a_ff;
    reg match_flag_b_ff;
    reg overflow_flag_ff;
    reg [2:0] irq_enable_ff;
    reg count_down_ff;
    reg block_ff;
    reg compare_output_state_a_ff;
    reg compare_output_state_b_ff;

    reg [7:0] nxt_count;
    reg nxt_down;
    reg [7:0] nxt_rdata;
    reg nxt_oc_a;
    reg nxt_oc_b;
    reg timer_tick;
    reg real_match_a;
    reg real_match_b;
    reg set_overflow;
    reg load_buffers;

    wire [2:0] wave_mode_field = {timer_control_b_ff[`CB_WAVE_BIT2],
        timer_control_a_ff[`CA_WAVE_HI:`CA_WAVE_LO]};
    wire [2:0] tick_source_select =
        timer_control_b_ff[`CB_TICK_HI:`CB_TICK_LO];
    wire [1:0] com_a =
        timer_control_a_ff[`CA_COM_A_HI:`CA_COM_A_LO];
    wire [1:0] com_b =
        timer_control_a_ff[`CA_COM_B_HI:`CA_COM_B_LO];
    wire mode_fast = (wave_mode_field == `WAVE_FAST_MAX) ||
        (wave_mode_field == `WAVE_FAST_CMPA);
    wire mode_pc = (wave_mode_field == `WAVE_PC_MAX) ||
        (wave_mode_field == `WAVE_PC_CMPA);
    wire mode_pwm = mode_fast || mode_pc;
    wire [7:0] top_value = (wave_mode_field == `WAVE_CTC ||
        wave_mode_field == `WAVE_FAST_CMPA ||
        wave_mode_field == `WAVE_PC_CMPA) ?
        compare_value_a_ff : `VAL_MAX;
    wire at_top = (count_value_ff == top_value);
    wire at_bottom = (count_value_ff == `VAL_BOTTOM);
    wire match_a = (count_value_ff == compare_value_a_ff);
    wire match_b = (count_value_ff == compare_value_b_ff);
    wire wr_count = wr_stb && (addr == `OFS_COUNT);
    wire wr_ctl_b = wr_stb && (addr == `OFS_CONTROL_B);
    wire force_a = wr_ctl_b && wdata[`CB_FORCE_A] && !mode_pwm;
    wire force_b = wr_ctl_b && wdata[`CB_FORCE_B] && !mode_pwm;
    wire clr_flags = wr_stb && (addr == `OFS_FLAGS);
    // Toggle on match for channel A only, in top-by-A PWM modes
    wire a_pwm_toggle = (com_a == `COM_TOGGLE) &&
        timer_control_b_ff[`CB_WAVE_BIT2];

    // ****************************************
    // Counter sequence
    // ****************************************
    always @* begin
        if (tick_source_select == `TICK_STOPPED)
            timer_tick = 1'b0;
        else
            timer_tick = tick_sources[tick_source_select - 3'h1];
        nxt_count = count_value_ff;
        nxt_down = count_down_ff;
        set_overflow = 1'b0;
        load_buffers = 1'b0;
        if (timer_tick) begin
            if (mode_pc) begin
                if (count_down_ff) begin
                    if (at_bottom) begin
                        nxt_down = 1'b0;
                        nxt_count = count_value_ff + 8'h01;
                        set_overflow = 1'b1;
                    end else begin
                        nxt_count = count_value_ff - 8'h01;
                    end
                end else if (at_top) begin
                    nxt_down = 1'b1;
                    nxt_count = count_value_ff - 8'h01;
                    load_buffers = 1'b1;
                end else begin
                    nxt_count = count_value_ff + 8'h01;
                end
            end else if (mode_fast) begin
                nxt_down = 1'b0;
                if (at_top) begin
                    nxt_count = `VAL_BOTTOM;
                    set_overflow = 1'b1;
                    load_buffers = 1'b1;
                end else begin
                    nxt_count = count_value_ff + 8'h01;
                end
            end else begin
                nxt_down = 1'b0;
                if (wave_mode_field == `WAVE_CTC && at_top)
                    nxt_count = `VAL_BOTTOM;
                else
                    nxt_count = count_value_ff + 8'h01;
                set_overflow = (count_value_ff == `VAL_MAX);
            end
        end
        if (wr_count) begin
            nxt_count = wdata;
            nxt_down = count_down_ff;
        end
        real_match_a = timer_tick && match_a && !block_ff;
        real_match_b = timer_tick && match_b && !block_ff;
    end

    // ****************************************
    // Compare output states
    // ****************************************
    always @* begin
        nxt_oc_a = compare_output_state_a_ff;
        nxt_oc_b = compare_output_state_b_ff;
        if (!mode_pwm) begin
            if (real_match_a || force_a)
                nxt_oc_a = plain_action(com_a, nxt_oc_a);
            if (real_match_b || force_b)
                nxt_oc_b = plain_action(com_b, nxt_oc_b);
        end else if (mode_fast) begin
            if (real_match_a)
                nxt_oc_a = a_pwm_toggle ? ~nxt_oc_a :
                    pwm_action(com_a, nxt_oc_a, 1'b1);
            else if (timer_tick && at_top && !a_pwm_toggle)
                nxt_oc_a = pwm_action(com_a, nxt_oc_a, 1'b0);
            if (real_match_b)
                nxt_oc_b = pwm_action(com_b, nxt_oc_b, 1'b1);
            else if (timer_tick && at_top)
                nxt_oc_b = pwm_action(com_b, nxt_oc_b, 1'b0);
        end else begin
            if (real_match_a)
                nxt_oc_a = a_pwm_toggle ? ~nxt_oc_a :
                    pwm_action(com_a, nxt_oc_a, count_down_ff);
            if (real_match_b)
                nxt_oc_b = pwm_action(com_b, nxt_oc_b, count_down_ff);
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always @* begin
        case (addr)
            `OFS_CONTROL_A: nxt_rdata = timer_control_a_ff;
            `OFS_CONTROL_B: nxt_rdata = {2'h0, timer_control_b_ff[5:0]};
            `OFS_COUNT: nxt_rdata = count_value_ff;
            `OFS_COMPARE_A: nxt_rdata = mode_pwm ? buffer_a_ff :
                compare_value_a_ff;
            `OFS_COMPARE_B: nxt_rdata = mode_pwm ? buffer_b_ff :
                compare_value_b_ff;
            `OFS_FLAGS: nxt_rdata = {5'h00, match_flag_b_ff,
                match_flag_a_ff, overflow_flag_ff};
            `OFS_IRQ_ENABLE: nxt_rdata = {5'h00, irq_enable_ff};
            default: nxt_rdata = `RST_BYTE;
        endcase
        if (!rd_stb)
            nxt_rdata = `RST_BYTE;
    end

    // ****************************************
    // Registers
    // ****************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_control_a_ff <= `RST_BYTE;
            timer_control_b_ff <= `RST_BYTE;
            count_value_ff <= `RST_BYTE;
            compare_value_a_ff <= `RST_BYTE;
            compare_value_b_ff <= `RST_BYTE;
            buffer_a_ff <= `RST_BYTE;
            buffer_b_ff <= `RST_BYTE;
            match_flag_a_ff <= 1'b0;
            match_flag_b_ff <= 1'b0;
            overflow_flag_ff <= 1'b0;
            irq_enable_ff <= 3'h0;
            count_down_ff <= 1'b0;
            block_ff <= 1'b0;
            compare_output_state_a_ff <= 1'b0;
            compare_output_state_b_ff <= 1'b0;
            rdata_ff <= `RST_BYTE;
            irq_match_a_ff <= 1'b0;
            irq_match_b_ff <= 1'b0;
            irq_overflow_ff <= 1'b0;
            pin_a_out_ff <= 1'b0;
            pin_a_oe_ff <= 1'b0;
            pin_b_out_ff <= 1'b0;
            pin_b_oe_ff <= 1'b0;
            at_bottom_ff <= 1'b1;
            at_max_ff <= 1'b0;
        end else begin
            if (wr_stb && addr == `OFS_CONTROL_A)
                timer_control_a_ff <= wdata;
            if (wr_ctl_b)
                timer_control_b_ff <= {2'h0, wdata[5:0]};
            if (wr_stb && addr == `OFS_IRQ_ENABLE)
                irq_enable_ff <= wdata[2:0];
            count_value_ff <= nxt_count;
            count_down_ff <= nxt_down;
            // Block holds until a tick passes, even while stopped
            if (wr_count)
                block_ff <= 1'b1;
            else if (timer_tick)
                block_ff <= 1'b0;
            // Compare value access and buffer load
            if (wr_stb && addr == `OFS_COMPARE_A) begin
                buffer_a_ff <= wdata;
                if (!mode_pwm)
                    compare_value_a_ff <= wdata;
            end else if (!mode_pwm) begin
                buffer_a_ff <= compare_value_a_ff;
            end
            if (wr_stb && addr == `OFS_COMPARE_B) begin
                buffer_b_ff <= wdata;
                if (!mode_pwm)
                    compare_value_b_ff <= wdata;
            end else if (!mode_pwm) begin
                buffer_b_ff <= compare_value_b_ff;
            end
            if (mode_pwm && load_buffers) begin
                compare_value_a_ff <= buffer_a_ff;
                compare_value_b_ff <= buffer_b_ff;
            end
            // Hardware set listed last so it wins over any clear
            if ((clr_flags && wdata[`FL_MATCH_A]) || ack_match_a)
                match_flag_a_ff <= 1'b0;
            if (real_match_a)
                match_flag_a_ff <= 1'b1;
            if ((clr_flags && wdata[`FL_MATCH_B]) || ack_match_b)
                match_flag_b_ff <= 1'b0;
            if (real_match_b)
                match_flag_b_ff <= 1'b1;
            if ((clr_flags && wdata[`FL_OVERFLOW]) || ack_overflow)
                overflow_flag_ff <= 1'b0;
            if (set_overflow && !wr_count)
                overflow_flag_ff <= 1'b1;
            compare_output_state_a_ff <= nxt_oc_a;
            compare_output_state_b_ff <= nxt_oc_b;
            rdata_ff <= nxt_rdata;
            // Request follows flag one cycle later, seen from flops
            irq_match_a_ff <= match_flag_a_ff &&
                irq_enable_ff[`FL_MATCH_A];
            irq_match_b_ff <= match_flag_b_ff &&
                irq_enable_ff[`FL_MATCH_B];
            irq_overflow_ff <= overflow_flag_ff &&
                irq_enable_ff[`FL_OVERFLOW];
            // Pin override ignores the wave mode
            pin_a_out_ff <= (com_a != `COM_OFF) ?
                compare_output_state_a_ff : port_value_a;
            pin_b_out_ff <= (com_b != `COM_OFF) ?
                compare_output_state_b_ff : port_value_b;
            pin_a_oe_ff <= output_pin_direction_a;
            pin_b_oe_ff <= output_pin_direction_b;
            at_bottom_ff <= (nxt_count == `VAL_BOTTOM);
            at_max_ff <= (nxt_count == `VAL_MAX);
        end
    end

endmodule
`default_nettype wire

// ### timer8_map.vh
// Register offsets, field positions and reset values of the 8-bit timer
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CONTROL_A 4'h0
`define OFS_CONTROL_B 4'h1
`define OFS_COUNT 4'h2
`define OFS_COMPARE_A 4'h3
`define OFS_COMPARE_B 4'h4
`define OFS_FLAGS 4'h5
`define OFS_IRQ_ENABLE 4'h6

// ****************************************
// Field positions
// ****************************************
`define CA_COM_A_HI 7
`define CA_COM_A_LO 6
`define CA_COM_B_HI 5
`define CA_COM_B_LO 4
`define CA_WAVE_HI 1
`define CA_WAVE_LO 0
`define CB_FORCE_A 7
`define CB_FORCE_B 6
`define CB_WAVE_BIT2 3
`define CB_TICK_HI 2
`define CB_TICK_LO 0
`define FL_MATCH_B 2
`define FL_MATCH_A 1
`define FL_OVERFLOW 0

// ****************************************
// Values and modes
// ****************************************
`define VAL_BOTTOM 8'h00
`define VAL_MAX 8'hff
`define RST_BYTE 8'h00
`define TICK_STOPPED 3'h0
`define WAVE_NORMAL 3'h0
`define WAVE_PC_MAX 3'h1
`define WAVE_CTC 3'h2
`define WAVE_FAST_MAX 3'h3
`define WAVE_PC_CMPA 3'h5
`define WAVE_FAST_CMPA 3'h7
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

`endif

// ### timer8_cc_chk.sv
// Port-level checker of the timer counter and compare unit
`timescale 1ns/1ps
`default_nettype none
module timer8_cc_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [6:0] tick_sources,
    input wire logic ack_match_a,
    input wire logic output_pin_direction_a,
    input wire logic output_pin_direction_b,
    input wire logic [7:0] rdata_ff,
    input wire logic irq_match_a_ff,
    input wire logic irq_overflow_ff,
    input wire logic pin_a_oe_ff,
    input wire logic pin_b_oe_ff,
    input wire logic at_bottom_ff,
    input wire logic at_max_ff
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire ev = (tick_sources != 7'h00) || wr_stb;
    ends_excl_a: assert property (!(at_bottom_ff && at_max_ff))
        else $error("bottom and max both high");
    dir_a_a: assert property (
        1'b1 |=> pin_a_oe_ff == $past(output_pin_direction_a))
        else $error("pin a enable not following direction");
    dir_b_a: assert property (
        1'b1 |=> pin_b_oe_ff == $past(output_pin_direction_b))
        else $error("pin b enable not following direction");
    rd_idle_a: assert property (!rd_stb |=> rdata_ff == 8'h00)
        else $error("read data outside read slot");
    // Three quiet cycles cover the registered lag of the ends
    no_step_a: assert property (
        !ev [*3] |=> $stable(at_bottom_ff) && $stable(at_max_ff))
        else $error("count moved without tick or write");
    // Max flop is loaded at the very edge that takes the tick or write
    max_cause_a: assert property (
        $rose(at_max_ff) |-> $past(ev))
        else $error("max reached without cause");
    match_irq_a: assert property (
        $rose(irq_match_a_ff) |-> $past(ev, 2) || $past(ev, 3))
        else $error("match request without tick");
    ovf_irq_a: assert property (
        $rose(irq_overflow_ff) |-> $past(ev, 2) || $past(ev, 3))
        else $error("overflow request without tick");
    irq_clear_a: assert property (
        $fell(irq_match_a_ff) |->
        $past(wr_stb || ack_match_a, 2) || $past(wr_stb || ack_match_a, 3))
        else $error("match request dropped without clear");
    cover property ($rose(irq_match_a_ff));
    cover property ($rose(irq_overflow_ff));
    cover property ($rose(at_max_ff));
endmodule
bind timer8_counter_compare_unit timer8_cc_chk chk_u (.clk(clk), .rst_b(rst_b),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .tick_sources(tick_sources),
    .ack_match_a(ack_match_a),
    .output_pin_direction_a(output_pin_direction_a),
    .output_pin_direction_b(output_pin_direction_b), .rdata_ff(rdata_ff),
    .irq_match_a_ff(irq_match_a_ff), .irq_overflow_ff(irq_overflow_ff),
    .pin_a_oe_ff(pin_a_oe_ff), .pin_b_oe_ff(pin_b_oe_ff),
    .at_bottom_ff(at_bottom_ff), .at_max_ff(at_max_ff));
`default_nettype wire

// ### port_pin_model.sv
// General port pin model: port latch, direction bit and pad level
`timescale 1ns/1ps
`default_nettype none
module port_pin_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic set_value,
    input wire logic set_dir,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic port_value_ff,
    output logic direction_ff,
    output logic pin_level
);
    logic last_ff;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_value_ff <= 1'b0;
            direction_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            port_value_ff <= set_value;
            direction_ff <= set_dir;
            if (pin_oe) begin
                last_ff <= pin_out;
            end
        end
    end
    // No pull on this pad, so a released pin must not look driven
    assign pin_level = pin_oe ? pin_out : ~last_ff;
endmodule
`default_nettype wire

// ### tb_timer8_counter_compare_unit.sv
// Self-checking bench of the timer counter and compare unit
`timescale 1ns/1ps
`default_nettype none
`include "timer8_map.vh"
module tb_timer8_counter_compare_unit;
    // ****************************************
    // Signals and instances
    // ****************************************
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    row_t rows [0:6] = '{'{`OFS_COMPARE_A, 8'h5a, 8'h5a},
        '{`OFS_COMPARE_B, 8'ha5, 8'ha5}, '{`OFS_COUNT, 8'h3c, 8'h3c},
        '{`OFS_CONTROL_B, 8'hc8, 8'h08}, '{`OFS_CONTROL_B, 8'h00, 8'h00},
        '{`OFS_IRQ_ENABLE, 8'hff, 8'h07}, '{4'hf, 8'hff, 8'h00}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [6:0] tick_sources = 7'h00;
    logic ack_a = 1'b0;
    logic ack_b = 1'b0;
    logic ack_ovf = 1'b0;
    logic set_val = 1'b0;
    logic set_dir = 1'b0;
    logic pval_b = 1'b0;
    logic pdir_b = 1'b1;
    logic [7:0] v;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    wire [7:0] rdata;
    wire irq_a, irq_b, irq_ovf, out_a, oe_a, out_b, oe_b, bot, mx;
    wire pval_a, pdir_a, pin_a;
    timer8_counter_compare_unit dut_u (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .tick_sources(tick_sources), .ack_match_a(ack_a), .ack_match_b(ack_b),
        .ack_overflow(ack_ovf), .port_value_a(pval_a), .port_value_b(pval_b),
        .output_pin_direction_a(pdir_a), .output_pin_direction_b(pdir_b),
        .rdata_ff(rdata), .irq_match_a_ff(irq_a), .irq_match_b_ff(irq_b),
        .irq_overflow_ff(irq_ovf), .pin_a_out_ff(out_a), .pin_a_oe_ff(oe_a),
        .pin_b_out_ff(out_b), .pin_b_oe_ff(oe_b), .at_bottom_ff(bot),
        .at_max_ff(mx));
    port_pin_model pin_u (.clk(clk), .rst_b(rst_b), .set_value(set_val),
        .set_dir(set_dir), .pin_out(out_a), .pin_oe(oe_a),
        .port_value_ff(pval_a), .direction_ff(pdir_a), .pin_level(pin_a));
    always #20 clk = ~clk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
        input string what);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic tick(input logic [6:0] s);
        @(posedge clk);
        tick_sources <= s;
        @(posedge clk);
        tick_sources <= 7'h00;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            finish_test();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        settle();
        chk(bot, 1'b1, "bottom");
        chk({out_a, out_b}, 2'b00, "states");
        rd(`OFS_COUNT, v);
        chk(v, `RST_BYTE, "count");
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk(v, rows[i].e, "readback");
        end
        $display("test table done");
        wr(`OFS_COUNT, 8'hfe);
        tick(7'h01);
        rd(`OFS_COUNT, v);
        chk(v, 8'hfe, "stopped count");
        wr(`OFS_CONTROL_B, 8'h01);
        tick(7'h02);
        tick(7'h01);
        rd(`OFS_COUNT, v);
        chk(v, 8'hff, "count step");
        chk(mx, 1'b1, "max");
        tick(7'h01);
        rd(`OFS_FLAGS, v);
        chk(v, 8'h01, "overflow flag");
        chk(irq_ovf, 1'b1, "overflow request");
        wr(`OFS_FLAGS, 8'h07);
        rd(`OFS_FLAGS, v);
        chk(v, 8'h00, "write-one clear");
        $display("test count done");
        wr(`OFS_COMPARE_A, 8'h05);
        wr(`OFS_COUNT, 8'h04);
        tick(7'h01);
        tick(7'h01);
        rd(`OFS_FLAGS, v);
        chk(v, 8'h02, "match flag");
        chk(irq_a, 1'b1, "match request");
        @(posedge clk);
        ack_a <= 1'b1;
        @(posedge clk);
        ack_a <= 1'b0;
        rd(`OFS_FLAGS, v);
        chk(v, 8'h00, "ack clear");
        wr(`OFS_COUNT, 8'h05);
        tick(7'h01);
        rd(`OFS_FLAGS, v);
        chk(v, 8'h00, "blocked match");
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= `OFS_COUNT;
        wdata <= 8'h80;
        tick_sources <= 7'h01;
        @(posedge clk);
        wr_stb <= 1'b0;
        tick_sources <= 7'h00;
        rd(`OFS_COUNT, v);
        chk(v, 8'h80, "write over step");
        $display("test match done");
        // Output state is set up before the pin is turned to output
        wr(`OFS_CONTROL_A, 8'h40);
        wr(`OFS_CONTROL_B, 8'h80);
        settle();
        chk(out_a, 1'b1, "forced toggle");
        rd(`OFS_FLAGS, v);
        chk(v, 8'h00, "forced no flag");
        rd(`OFS_COUNT, v);
        chk(v, 8'h80, "forced no reload");
        @(posedge clk);
        set_dir <= 1'b1;
        settle();
        chk({oe_a, pin_a}, 2'b11, "pin shows state");
        wr(`OFS_CONTROL_A, 8'h43);
        settle();
        chk(out_a, 1'b1, "state kept");
        wr(`OFS_CONTROL_A, 8'h00);
        settle();
        chk(out_a, 1'b0, "port value back");
        $display("test force done");
        wr(`OFS_COMPARE_B, 8'h82);
        wr(`OFS_COUNT, 8'h81);
        wr(`OFS_CONTROL_B, 8'h01);
        tick(7'h01);
        tick(7'h01);
        rd(`OFS_FLAGS, v);
        chk(v, 8'h04, "match flag b");
        chk(irq_b, 1'b1, "match request b");
        wr(`OFS_FLAGS, 8'h04);
        $display("test channel b done");
        // Fast PWM with top from A: a compare write waits for top
        wr(`OFS_CONTROL_A, 8'h03);
        wr(`OFS_CONTROL_B, 8'h09);
        wr(`OFS_COMPARE_A, 8'h07);
        rd(`OFS_COMPARE_A, v);
        chk(v, 8'h07, "buffer read");
        wr(`OFS_COUNT, 8'h04);
        tick(7'h01);
        tick(7'h01);
        rd(`OFS_COUNT, v);
        chk(v, `VAL_BOTTOM, "wrap at old top");
        rd(`OFS_FLAGS, v);
        chk(v, 8'h03, "top flags");
        wr(`OFS_CONTROL_A, 8'h00);
        wr(`OFS_CONTROL_B, 8'h01);
        rd(`OFS_COMPARE_A, v);
        chk(v, 8'h07, "buffer loaded at top");
        $display("test buffer done");
        finish_test();
    end
endmodule
`default_nettype wire
